// >>> hw/sss_supervisor_ctrl.sv
// module: supply supervisor mode controller with register port
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps
module sss_supervisor_ctrl #(
  parameter int SLOW_CYCLES = sss_pkg::SLOW_SETTLE_CYCLES,
  parameter int FAST_CYCLES = sss_pkg::FAST_SETTLE_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sss_pkg::ADDR_W-1:0] addr,
  input wire logic [sss_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [sss_pkg::DATA_W-1:0] rdata,
  input wire sss_pkg::sss_power_mode_t power_mode,
  input wire logic subsystem_clock_from_oscillator,
  output sss_pkg::sss_states_t sv_states,
  output logic cpu_mask,
  output logic subsystem_clock_hold,
  output logic fast_wakeup,
  output logic irq
);

  // control registers for both sides
  sss_pkg::sss_ctl_t core_side_supervisor_control;
  sss_pkg::sss_ctl_t supply_side_supervisor_control;
  logic [sss_pkg::FLG_W-1:0] flags;
  logic [sss_pkg::FLG_W-1:0] irq_mask;
  logic [1:0] settle_pending;
  logic [1:0] settle_done;
  sss_pkg::sss_wake_t wake_state;
  logic [CNT_W-1:0] mask_cnt;
  logic deep_34;
  logic wake_done;
  logic in_deep;
  logic next_fast;
  logic core_sup_fast;
  logic core_mon_fast;
  logic [sss_pkg::STS_W-1:0] status;
  logic [sss_pkg::FLG_W-1:0] events;
  logic flags_read;
  sss_pkg::sss_states_t next_states;

  localparam logic [CNT_W-1:0] SLOW_CNT = CNT_W'(SLOW_CYCLES);
  localparam logic [CNT_W-1:0] FAST_CNT = CNT_W'(FAST_CYCLES);

  // supervisor state in the given mode
  function automatic sss_pkg::sss_sv_state_t sup_map(
    input sss_pkg::sss_ctl_t c,
    input logic deep
  );
    sss_pkg::sss_sv_state_t act;
    act = c.supervisor_full_perf ? sss_pkg::SV_FULL : sss_pkg::SV_NORMAL;
    if (!c.supervisor_enable) begin
      sup_map = sss_pkg::SV_OFF;
    end else if (!deep) begin
      sup_map = act;
    end else if (!c.keep_in_sleep) begin
      sup_map = sss_pkg::SV_OFF;
    end else if (c.auto_control) begin
      sup_map = c.supervisor_full_perf ? sss_pkg::SV_NORMAL : sss_pkg::SV_OFF;
    end else begin
      sup_map = act;
    end
  endfunction

  // monitor state in the given mode
  function automatic sss_pkg::sss_sv_state_t mon_map(
    input sss_pkg::sss_ctl_t c,
    input logic deep
  );
    sss_pkg::sss_sv_state_t act;
    act = c.monitor_full_perf ? sss_pkg::SV_FULL : sss_pkg::SV_NORMAL;
    if (!c.monitor_enable) begin
      mon_map = sss_pkg::SV_OFF;
    end else if (deep && c.auto_control) begin
      mon_map = c.monitor_full_perf ? sss_pkg::SV_NORMAL : sss_pkg::SV_OFF;
    end else begin
      mon_map = act;
    end
  endfunction

  // deep sleep covers modes two, three and four
  assign in_deep = (power_mode == sss_pkg::PM_SLEEP_TWO) ||
                   (power_mode == sss_pkg::PM_SLEEP_THREE) ||
                   (power_mode == sss_pkg::PM_SLEEP_FOUR);

  // per-mode selection for all four units
  always_comb begin
    next_states.core_sup = sup_map(core_side_supervisor_control, in_deep);
    next_states.core_mon = mon_map(core_side_supervisor_control, in_deep);
    next_states.supply_sup = sup_map(supply_side_supervisor_control, in_deep);
    next_states.supply_mon = mon_map(supply_side_supervisor_control, in_deep);
  end

  // wake speed: slow only when a core unit runs in normal performance
  assign core_sup_fast = !core_side_supervisor_control.supervisor_enable ||
                         core_side_supervisor_control.supervisor_full_perf;
  assign core_mon_fast = !core_side_supervisor_control.monitor_enable ||
                         core_side_supervisor_control.monitor_full_perf;
  assign next_fast = core_sup_fast && core_mon_fast;

  always_ff @(posedge clk) begin
    if (rst) begin
      sv_states <= '{sss_pkg::SV_NORMAL, sss_pkg::SV_NORMAL,
                     sss_pkg::SV_NORMAL, sss_pkg::SV_NORMAL};
    end else begin
      sv_states <= next_states;
    end
  end

  // control register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      core_side_supervisor_control <= sss_pkg::CTL_RESET;
      supply_side_supervisor_control <= sss_pkg::CTL_RESET;
      irq_mask <= sss_pkg::MASK_RESET;
    end else if (wr) begin
      case (addr)
        sss_pkg::CORE_CTL_OFS: begin
          core_side_supervisor_control <= wdata[sss_pkg::CTL_W-1:0];
        end
        sss_pkg::SUPPLY_CTL_OFS: begin
          supply_side_supervisor_control <= wdata[sss_pkg::CTL_W-1:0];
        end
        sss_pkg::IRQ_MASK_OFS: begin
          irq_mask <= wdata[sss_pkg::FLG_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // settle timers, one per side
  for (genvar i = 0; i < 2; i++) begin : g_settle
    logic [CNT_W-1:0] cnt;
    logic hit;
    logic new_fp;
    assign hit = wr && (addr == (i == 0 ? sss_pkg::CORE_CTL_OFS
                                        : sss_pkg::SUPPLY_CTL_OFS));
    // supervisor full performance (bit 2) in the written word picks the short delay
    assign new_fp = wdata[2];
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt <= '0;
        settle_pending[i] <= 1'b0;
        settle_done[i] <= 1'b0;
      end else if (hit) begin
        settle_pending[i] <= 1'b1;
        cnt <= new_fp ? FAST_CNT : SLOW_CNT;
        settle_done[i] <= 1'b0;
      end else if (settle_pending[i]) begin
        cnt <= cnt - CNT_W'(1);
        settle_done[i] <= (cnt == CNT_W'(1));
        settle_pending[i] <= (cnt != CNT_W'(1));
      end else begin
        settle_done[i] <= 1'b0;
      end
    end
  end

  // wake-up sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_state <= sss_pkg::WK_AWAKE;
      fast_wakeup <= 1'b0;
      deep_34 <= 1'b0;
      mask_cnt <= '0;
      cpu_mask <= 1'b0;
      wake_done <= 1'b0;
    end else begin
      wake_done <= 1'b0;
      case (wake_state)
        sss_pkg::WK_AWAKE: begin
          if (in_deep) begin
            // wake speed latched at sleep entry
            fast_wakeup <= next_fast;
            deep_34 <= (power_mode != sss_pkg::PM_SLEEP_TWO);
            wake_state <= sss_pkg::WK_ASLEEP;
          end
        end
        sss_pkg::WK_ASLEEP: begin
          if (in_deep) begin
            deep_34 <= deep_34 || (power_mode != sss_pkg::PM_SLEEP_TWO);
          end else if (deep_34) begin
            mask_cnt <= fast_wakeup ? FAST_CNT : SLOW_CNT;
            cpu_mask <= 1'b1;
            wake_state <= sss_pkg::WK_MASKING;
          end else begin
            wake_done <= 1'b1;
            wake_state <= sss_pkg::WK_AWAKE;
          end
        end
        sss_pkg::WK_MASKING: begin
          mask_cnt <= mask_cnt - CNT_W'(1);
          if (mask_cnt == CNT_W'(1)) begin
            cpu_mask <= 1'b0;
            wake_done <= 1'b1;
            wake_state <= sss_pkg::WK_AWAKE;
          end
        end
        default: begin
          wake_state <= sss_pkg::WK_AWAKE;
        end
      endcase
    end
  end

  // subsystem clock held only when not from the oscillator
  always_ff @(posedge clk) begin
    if (rst) begin
      subsystem_clock_hold <= 1'b0;
    end else begin
      subsystem_clock_hold <= (wake_state == sss_pkg::WK_MASKING) &&
                              !(mask_cnt == CNT_W'(1)) &&
                              !subsystem_clock_from_oscillator;
    end
  end

  // event vector for the sticky flags
  always_comb begin
    events = '0;
    events[sss_pkg::FLG_CORE_SETTLED] = settle_done[0];
    events[sss_pkg::FLG_SUPPLY_SETTLED] = settle_done[1];
    events[sss_pkg::FLG_WAKE_DONE] = wake_done;
  end

  assign flags_read = rd && (addr == sss_pkg::FLAGS_OFS);

  // sticky flags: a read clears, a new event wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= (flags_read ? '0 : flags) | events;
    end
  end

  // level interrupt from unmasked flags
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((flags_read ? '0 : flags) | events) & irq_mask);
    end
  end

  // live status word
  always_comb begin
    status = '0;
    status[sss_pkg::STS_CORE_PEND] = settle_pending[0];
    status[sss_pkg::STS_SUPPLY_PEND] = settle_pending[1];
    status[sss_pkg::STS_FAST_WAKE] = fast_wakeup;
    status[sss_pkg::STS_CPU_MASK] = cpu_mask;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        sss_pkg::CORE_CTL_OFS: begin
          rdata <= {26'h0, core_side_supervisor_control};
        end
        sss_pkg::SUPPLY_CTL_OFS: begin
          rdata <= {26'h0, supply_side_supervisor_control};
        end
        sss_pkg::FLAGS_OFS: begin
          rdata <= {29'h0, flags};
        end
        sss_pkg::IRQ_MASK_OFS: begin
          rdata <= {29'h0, irq_mask};
        end
        sss_pkg::STATUS_OFS: begin
          rdata <= {28'h0, status};
        end
        default: begin
          rdata <= '0;
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule // sss_supervisor_ctrl

// >>> hw/sss_pkg.sv
// package: constants and types of the supply supervisor mode controller
package sss_pkg;
  // clock period and documented times
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_SETTLE_US = 2;
  localparam int SLOW_SETTLE_US = 150;
  localparam int FAST_SETTLE_CYCLES = FAST_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOW_SETTLE_CYCLES = SLOW_SETTLE_US * 1000 / CLK_PERIOD_NS;
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CORE_CTL_OFS = 8'h00;
  localparam logic [7:0] SUPPLY_CTL_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // sticky event flag positions (flags and mask share the layout)
  localparam int FLG_CORE_SETTLED = 0;
  localparam int FLG_SUPPLY_SETTLED = 1;
  localparam int FLG_WAKE_DONE = 2;
  localparam int FLG_W = 3;
  // live status positions
  localparam int STS_CORE_PEND = 0;
  localparam int STS_SUPPLY_PEND = 1;
  localparam int STS_FAST_WAKE = 2;
  localparam int STS_CPU_MASK = 3;
  localparam int STS_W = 4;
  // supervisor control word, one per side
  typedef struct packed {
    logic auto_control;
    logic monitor_full_perf;
    logic monitor_enable;
    logic supervisor_full_perf;
    logic keep_in_sleep;
    logic supervisor_enable;
  } sss_ctl_t;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTL_RESET = 6'h09;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // power modes
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'h0,
    PM_LIGHT = 3'h1,
    PM_SLEEP_TWO = 3'h2,
    PM_SLEEP_THREE = 3'h3,
    PM_SLEEP_FOUR = 3'h4
  } sss_power_mode_t;
  // supervisor or monitor operating state
  typedef enum logic [1:0] {
    SV_OFF = 2'h0,
    SV_NORMAL = 2'h1,
    SV_FULL = 2'h3
  } sss_sv_state_t;
  typedef struct packed {
    sss_sv_state_t core_sup;
    sss_sv_state_t core_mon;
    sss_sv_state_t supply_sup;
    sss_sv_state_t supply_mon;
  } sss_states_t;
  // wake-up sequencer states, gray along awake-asleep-masking
  typedef enum logic [1:0] {
    WK_AWAKE = 2'h0,
    WK_ASLEEP = 2'h1,
    WK_MASKING = 2'h3
  } sss_wake_t;
endpackage

// >>> verification/sss_supervisor_checker.sv
// checker: concurrent assertions on the supervisor controller ports
`timescale 1ns/100ps
module sss_supervisor_checker #(
  parameter int SLOW_CYCLES = sss_pkg::SLOW_SETTLE_CYCLES,
  parameter int FAST_CYCLES = sss_pkg::FAST_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sss_pkg::ADDR_W-1:0] addr,
  input wire logic [sss_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire sss_pkg::sss_power_mode_t power_mode,
  input wire logic subsystem_clock_from_oscillator,
  input wire sss_pkg::sss_states_t sv_states,
  input wire logic cpu_mask,
  input wire logic subsystem_clock_hold,
  input wire logic fast_wakeup
);
  logic [5:0] cc;
  logic [5:0] sc;
  logic deep;
  int mcnt;
  logic slept_deep;
  // remember a visit to sleep three or four since the last mask
  always_ff @(posedge clk) begin
    if (rst) begin
      slept_deep <= 1'b0;
    end else if (cpu_mask) begin
      slept_deep <= 1'b0;
    end else if (power_mode >= sss_pkg::PM_SLEEP_THREE) begin
      slept_deep <= 1'b1;
    end
  end
  // mirror control writes and count mask length
  always_ff @(posedge clk) begin
    if (rst) begin
      cc <= 6'h09;
      sc <= 6'h09;
      mcnt <= 0;
    end else begin
      if (wr && addr == sss_pkg::CORE_CTL_OFS) cc <= wdata[5:0];
      if (wr && addr == sss_pkg::SUPPLY_CTL_OFS) sc <= wdata[5:0];
      mcnt <= cpu_mask ? mcnt + 1 : 0;
    end
  end
  // deep sleep modes two to four
  assign deep = power_mode >= sss_pkg::PM_SLEEP_TWO;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_core_held;
    !$past(rst) && $stable(cc);
  endsequence
  sequence s_supply_held;
    !$past(rst) && $stable(sc);
  endsequence
  sequence s_wake;
    $rose(cpu_mask);
  endsequence
  property p_core_off;
    s_core_held ##0 !cc[0] |-> sv_states.core_sup == sss_pkg::SV_OFF;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("core supervisor not off while disabled");
  property p_core_drop;
    s_core_held ##0 (cc[1:0] == 2'h1 && $past(deep))
      |-> sv_states.core_sup == sss_pkg::SV_OFF;
  endproperty
  a_core_drop: assert property (p_core_drop)
    else $error("core supervisor not off in deep sleep");
  property p_core_keep;
    s_core_held ##0 (cc[1:0] == 2'h3 && !cc[5] && $past(deep))
      |-> sv_states.core_sup == (cc[2] ? sss_pkg::SV_FULL : sss_pkg::SV_NORMAL);
  endproperty
  a_core_keep: assert property (p_core_keep)
    else $error("core supervisor not kept under manual control");
  property p_core_auto;
    s_core_held ##0 (cc[1:0] == 2'h3 && cc[5] && $past(deep))
      |-> sv_states.core_sup == (cc[2] ? sss_pkg::SV_NORMAL : sss_pkg::SV_OFF);
  endproperty
  a_core_auto: assert property (p_core_auto)
    else $error("core supervisor not lowered under automatic control");
  property p_supply_mon;
    s_supply_held ##0 (sc[3] && sc[5] && $past(deep))
      |-> sv_states.supply_mon == (sc[4] ? sss_pkg::SV_NORMAL : sss_pkg::SV_OFF);
  endproperty
  a_supply_mon: assert property (p_supply_mon)
    else $error("supply monitor not lowered under automatic control");
  property p_mask_len;
    $fell(cpu_mask) |-> mcnt == (fast_wakeup ? FAST_CYCLES : SLOW_CYCLES);
  endproperty
  a_mask_len: assert property (p_mask_len)
    else $error("cpu mask length wrong");
  property p_mask_cause;
    s_wake |-> slept_deep && $past(power_mode) < sss_pkg::PM_SLEEP_TWO;
  endproperty
  a_mask_cause: assert property (p_mask_cause)
    else $error("cpu mask without wake from deepest sleep");
  property p_osc_hold;
    cpu_mask && subsystem_clock_from_oscillator
      && $past(subsystem_clock_from_oscillator) |-> !subsystem_clock_hold;
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("subsystem clock held while from oscillator");
endmodule // sss_supervisor_checker
bind sss_supervisor_ctrl sss_supervisor_checker #(
  .SLOW_CYCLES(SLOW_CYCLES),
  .FAST_CYCLES(FAST_CYCLES)
) chk_i (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .power_mode(power_mode),
  .subsystem_clock_from_oscillator(subsystem_clock_from_oscillator),
  .sv_states(sv_states),
  .cpu_mask(cpu_mask),
  .subsystem_clock_hold(subsystem_clock_hold),
  .fast_wakeup(fast_wakeup)
);

// >>> verification/test_sss_supervisor_ctrl.sv
// testbench: model-checked runs of the supervisor controller
`timescale 1ns/100ps
module test_sss_supervisor_ctrl;
  localparam int SLOW = 40;
  localparam int FAST = 5;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 0;
  logic rd = 0;
  logic osc = 0;
  sss_pkg::sss_power_mode_t power_mode = sss_pkg::PM_ACTIVE;
  logic [31:0] rdata;
  sss_pkg::sss_states_t sv_states;
  logic cpu_mask, hold, fast_wakeup, irq;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h00000018;
  logic [31:0] d;
  logic [5:0] cc, sc;
  logic [2:0] m;
  int dp;
  sss_supervisor_ctrl #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST), .CNT_W(16))
    sss_supervisor_ctrl_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .power_mode(power_mode),
    .subsystem_clock_from_oscillator(osc), .sv_states(sv_states),
    .cpu_mask(cpu_mask), .subsystem_clock_hold(hold),
    .fast_wakeup(fast_wakeup), .irq(irq));
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // model: state of one unit, s selects supervisor
  function automatic logic [1:0] mp(input logic [5:0] c, input int s,
                                    input int dp);
    logic e, k, f;
    e = s ? c[0] : c[3];
    k = s ? c[1] : 1'b1;
    f = s ? c[2] : c[4];
    if (!e) return 2'h0;
    if (dp == 0 || (k && !c[5])) return f ? 2'h3 : 2'h1;
    if (k && f) return 2'h1;
    return 2'h0;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle_wait();
    do rreg(sss_pkg::STATUS_OFS); while (d[1:0] != 2'h0);
  endtask
  // sleep in mode md, wake, count mask and clock hold cycles
  task automatic wake(input logic [5:0] c, input int md, input logic o,
                      input int n);
    int cnt = 0;
    int hc = 0;
    wreg(sss_pkg::CORE_CTL_OFS, 32'(c));
    settle_wait();
    @(posedge clk);
    power_mode <= sss_pkg::sss_power_mode_t'(3'(md));
    osc <= o;
    repeat (3) @(posedge clk);
    #1 chk(32'(fast_wakeup), 32'((!c[0] || c[2]) && (!c[3] || c[4])));
    @(posedge clk);
    power_mode <= sss_pkg::PM_ACTIVE;
    repeat (SLOW + 10) begin
      @(posedge clk);
      #1 if (cpu_mask === 1'b1) cnt++;
      if (hold === 1'b1) hc++;
    end
    chk(cnt, n);
    chk(hc, (o || n == 0) ? 0 : n - 1);
    rreg(sss_pkg::FLAGS_OFS);
    chk(32'(d[2]), 1);
  endtask
  // watchdog
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk(32'(sv_states), 32'h55);
    rreg(sss_pkg::CORE_CTL_OFS);
    chk(d, 32'h09);
    rreg(sss_pkg::SUPPLY_CTL_OFS);
    chk(d, 32'h09);
    rreg(sss_pkg::IRQ_MASK_OFS);
    chk(d, 32'h0);
    wreg(8'h20, 32'hffffffff);
    rreg(8'h20);
    chk(d, 32'h0);
    repeat (40) begin
      cc = 6'(xs());
      sc = 6'(xs());
      m = 3'(xs() % 5);
      wreg(sss_pkg::CORE_CTL_OFS, 32'(cc));
      wreg(sss_pkg::SUPPLY_CTL_OFS, 32'(sc));
      settle_wait();
      @(posedge clk);
      power_mode <= sss_pkg::sss_power_mode_t'(m);
      repeat (3) @(posedge clk);
      #1 dp = int'(m >= 3'h2);
      chk(32'(sv_states), 32'({mp(cc, 1, dp), mp(cc, 0, dp), mp(sc, 1, dp),
          mp(sc, 0, dp)}));
    end
    @(posedge clk);
    power_mode <= sss_pkg::PM_ACTIVE;
    repeat (SLOW + 10) @(posedge clk);
    wake(6'h09, 3, 1'b0, SLOW);
    wake(6'h00, 4, 1'b1, FAST);
    wake(6'h1d, 3, 1'b0, FAST);
    wake(6'h18, 4, 1'b0, FAST);
    wake(6'h09, 2, 1'b0, 0);
    repeat (SLOW) @(posedge clk);
    rreg(sss_pkg::FLAGS_OFS);
    wreg(sss_pkg::IRQ_MASK_OFS, 32'h7);
    wreg(sss_pkg::CORE_CTL_OFS, 32'h05);
    wreg(sss_pkg::SUPPLY_CTL_OFS, 32'h09);
    rreg(sss_pkg::STATUS_OFS);
    chk(32'(d[1:0]), 32'h3);
    repeat (FAST + 3) @(posedge clk);
    #1 chk(32'(irq), 1);
    rreg(sss_pkg::FLAGS_OFS);
    chk(32'(d[1:0]), 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 0);
    repeat (SLOW) @(posedge clk);
    #1 chk(32'(irq), 1);
    tally_and_finish();
  end
endmodule // test_sss_supervisor_ctrl
